// >>> capture_pipe_ctrl.sv
`timescale 1ns/1ns
// How it works
// - Capture runs memory-to-memory when select bit 19 set and a pipe feeds.
// - Pass completion clears the capture path enable bit 0 by hardware.
// - Pass completion leaves the feeding pipe's enable bit 0 untouched.
// - Stale pipe rerouted to live panel connects at once, unaligned to frame.
// - That unsynchronized join raises sync-lost; exactly one frame corrupts.
module capture_pipe_ctrl #(
    parameter int unsigned PASS_CYCLES  = capture_pkg::PASS_CYCLES,
    parameter int unsigned FRAME_CYCLES = capture_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    // Interrupt
    output logic                               irq,
    // Panel and capture output state
    output logic [capture_pkg::NUM_PIPES-1:0]  panel_live,
    output logic                               frame_corrupt,
    output logic                               capture_busy
);
    import capture_pkg::*;

    localparam logic [15:0] PASS_LAST = 16'(PASS_CYCLES - 1);

    cap_state_t           cap_state;
    cap_state_t           next_cap_state;
    logic [15:0]          pass_count;
    logic [15:0]          next_pass_count;
    logic                 capt_en;
    logic                 next_capt_en;
    logic                 capt_sel;
    logic                 next_capt_sel;
    logic [NUM_PIPES-1:0] vid_en;
    logic [NUM_PIPES-1:0] next_vid_en;
    logic [NUM_PIPES-1:0] vid_route;
    logic [NUM_PIPES-1:0] next_vid_route;
    logic [NUM_PIPES-1:0] stale;
    logic [NUM_PIPES-1:0] next_stale;
    logic [NUM_PIPES-1:0] next_panel_live;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     next_irq_status;
    logic [IRQ_W-1:0]     irq_enable;
    logic [IRQ_W-1:0]     next_irq_enable;
    logic                 next_irq;
    logic                 panel_on;
    logic                 next_panel_on;
    logic [7:0]           corrupt_count;
    logic [7:0]           next_corrupt_count;
    logic                 next_frame_corrupt;
    logic                 next_capture_busy;
    logic                 next_pready;
    logic [31:0]          next_prdata;
    logic                 next_pslverr;
    logic                 frame_start;
    logic                 access;
    logic                 wr;
    logic                 feed;
    logic                 pass_done;
    logic                 unsync;
    logic [IRQ_W-1:0]     events;

    panel_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_timer (
        .pclk        (pclk),
        .presetn     (presetn),
        .panel_on    (panel_on),
        .frame_start (frame_start)
    );

    // Offset of the attribute word of one video layer.
    function automatic logic [7:0] vid_off(input int idx);
        vid_off = 8'(VID_ATTR0_OFF + 8'(4 * idx));
    endfunction

    // A layer is aimed at the panel when enabled and not routed to capture.
    function automatic logic to_panel(input logic en, input logic route);
        to_panel = en & ~route;
    endfunction

    assign access    = psel & penable & ~pready;
    assign wr        = psel & penable & pready & pwrite;
    assign feed      = |(vid_en & vid_route);
    assign pass_done = (cap_state == CAP_RUN) && (pass_count == PASS_LAST);

    // APB answer: pready rises one cycle into the access phase, so every
    // access takes exactly two cycles and writes commit with pready high.
    always_comb begin
        next_pready  = access;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (access) begin
            next_pslverr = 1'b1;
            if (paddr == CAPT_ATTR_OFF) begin
                next_prdata[CAPT_EN_BIT]  = capt_en;
                next_prdata[CAPT_SEL_BIT] = capt_sel;
                next_pslverr              = 1'b0;
            end
            for (int i = 0; i < NUM_PIPES; i++) begin
                if (paddr == vid_off(i)) begin
                    next_prdata[VID_EN_BIT]    = vid_en[i];
                    next_prdata[VID_ROUTE_BIT] = vid_route[i];
                    next_pslverr               = 1'b0;
                end
            end
            if (paddr == IRQ_STATUS_OFF) begin
                next_prdata[IRQ_W-1:0] = irq_status;
                next_pslverr           = 1'b0;
            end
            if (paddr == IRQ_CLEAR_OFF) begin
                next_pslverr = 1'b0;
            end
            if (paddr == IRQ_ENABLE_OFF) begin
                next_prdata[IRQ_W-1:0] = irq_enable;
                next_pslverr           = 1'b0;
            end
            if (paddr == STATUS_OFF) begin
                next_prdata[NUM_PIPES-1:0] = panel_live;
                next_prdata[STAT_BUSY_BIT] = capture_busy;
                next_prdata[STAT_CORR_BIT] = frame_corrupt;
                next_prdata[STAT_COUNT_LSB +: 8] = corrupt_count;
                next_pslverr = 1'b0;
            end
            if (paddr == PANEL_CTRL_OFF) begin
                next_prdata[PANEL_ON_BIT] = panel_on;
                next_pslverr              = 1'b0;
            end
        end
    end

    always_comb begin
        next_cap_state     = cap_state;
        next_pass_count    = pass_count;
        next_capt_en       = capt_en;
        next_capt_sel      = capt_sel;
        next_vid_en        = vid_en;
        next_vid_route     = vid_route;
        next_stale         = stale;
        next_panel_on      = panel_on;
        next_irq_enable    = irq_enable;
        next_corrupt_count = corrupt_count;
        next_frame_corrupt = frame_corrupt;
        unsync             = 1'b0;
        events             = '0;
        unique case (cap_state)
            CAP_IDLE: begin
                if (capt_en && capt_sel && feed) begin
                    next_cap_state  = CAP_RUN;
                    next_pass_count = 16'h0000;
                end
            end
            CAP_RUN: begin
                next_pass_count = pass_count + 16'h0001;
                if (pass_done) begin
                    next_cap_state = CAP_IDLE;
                    // The feeding layer keeps its enable and is now stale.
                    next_capt_en = 1'b0;
                    events[IRQ_DONE_BIT] = 1'b1;
                end else if (!capt_en) begin
                    next_cap_state = CAP_IDLE;
                end
            end
        endcase
        if (wr && paddr == CAPT_ATTR_OFF) begin
            next_capt_en  = pwdata[CAPT_EN_BIT];
            next_capt_sel = pwdata[CAPT_SEL_BIT];
            // Clearing capture enable flushes only layers already disabled.
            if (capt_en && !pwdata[CAPT_EN_BIT]) begin
                next_stale = stale & vid_en;
            end
        end
        if (pass_done) begin
            next_stale = next_stale | (vid_en & vid_route);
        end
        if (wr && paddr == PANEL_CTRL_OFF) begin
            next_panel_on = pwdata[PANEL_ON_BIT];
        end
        if (wr && paddr == IRQ_ENABLE_OFF) begin
            next_irq_enable = pwdata[IRQ_W-1:0];
        end
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (wr && paddr == vid_off(i)) begin
                // Route and settings may change freely while disabled.
                next_vid_en[i]    = pwdata[VID_EN_BIT];
                next_vid_route[i] = pwdata[VID_ROUTE_BIT];
                if (stale[i] && panel_on &&
                    to_panel(pwdata[VID_EN_BIT], pwdata[VID_ROUTE_BIT])) begin
                    unsync        = 1'b1;
                    next_stale[i] = 1'b0;
                end
            end
        end
        if (frame_start) begin
            next_frame_corrupt = 1'b0;
        end
        if (unsync) begin
            next_frame_corrupt   = 1'b1;
            next_corrupt_count   = corrupt_count + 8'h01;
            events[IRQ_SYNC_BIT] = 1'b1;
        end
    end

    // Panel connections: a clean layer waits for the frame start, a stale
    // one forced onto the live panel connects in mid-frame.
    always_comb begin
        next_panel_live = panel_live;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (!panel_on ||
                !to_panel(next_vid_en[i], next_vid_route[i])) begin
                next_panel_live[i] = 1'b0;
            end else if (unsync && wr && paddr == vid_off(i)) begin
                next_panel_live[i] = 1'b1;
            end else if (frame_start && !stale[i]) begin
                next_panel_live[i] = 1'b1;
            end
        end
        next_capture_busy = (next_cap_state == CAP_RUN);
    end

    // A new event wins over a clear written in the same cycle.
    always_comb begin
        next_irq_status = irq_status;
        if (wr && paddr == IRQ_CLEAR_OFF) begin
            next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_irq        = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_state     <= CAP_IDLE;
            pass_count    <= 16'h0000;
            capt_en       <= REG_RESET[CAPT_EN_BIT];
            capt_sel      <= REG_RESET[CAPT_SEL_BIT];
            vid_en        <= '0;
            vid_route     <= '0;
            stale         <= '0;
            panel_on      <= REG_RESET[PANEL_ON_BIT];
            irq_status    <= '0;
            irq_enable    <= '0;
            irq           <= 1'b0;
            corrupt_count <= 8'h00;
            frame_corrupt <= 1'b0;
            panel_live    <= '0;
            capture_busy  <= 1'b0;
            pready        <= 1'b0;
            prdata        <= 32'h0000_0000;
            pslverr       <= 1'b0;
        end else begin
            cap_state     <= next_cap_state;
            pass_count    <= next_pass_count;
            capt_en       <= next_capt_en;
            capt_sel      <= next_capt_sel;
            vid_en        <= next_vid_en;
            vid_route     <= next_vid_route;
            stale         <= next_stale;
            panel_on      <= next_panel_on;
            irq_status    <= next_irq_status;
            irq_enable    <= next_irq_enable;
            irq           <= next_irq;
            corrupt_count <= next_corrupt_count;
            frame_corrupt <= next_frame_corrupt;
            panel_live    <= next_panel_live;
            capture_busy  <= next_capture_busy;
            pready        <= next_pready;
            prdata        <= next_prdata;
            pslverr       <= next_pslverr;
        end
    end

    a_pass_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_state == CAP_IDLE && capt_en && capt_sel && feed
        |=> cap_state == CAP_RUN && pass_count == 16'h0000)
        else $error("pass did not start");

    a_no_select_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_state == CAP_IDLE && !capt_sel |=> cap_state == CAP_IDLE)
        else $error("pass started without select");

    a_done_clears_en: assert property (
        @(posedge pclk) disable iff (!presetn)
        pass_done && !(wr && paddr == CAPT_ATTR_OFF)
        |=> !capt_en && irq_status[IRQ_DONE_BIT])
        else $error("capture enable not cleared at done");

    a_pipe_kept_en: assert property (
        @(posedge pclk) disable iff (!presetn)
        pass_done && !wr |=> vid_en == $past(vid_en) && (stale != '0))
        else $error("layer enable changed at done");

    a_unsync_join: assert property (
        @(posedge pclk) disable iff (!presetn)
        unsync |=> (panel_live & ~$past(panel_live)) != '0)
        else $error("unsynchronized join did not connect");

    a_join_aligned: assert property (
        @(posedge pclk) disable iff (!presetn)
        !frame_start && !unsync |=> (panel_live & ~$past(panel_live)) == '0)
        else $error("layer joined outside frame start");

    a_sync_lost_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        unsync |=> irq_status[IRQ_SYNC_BIT] && frame_corrupt
                   && corrupt_count == $past(corrupt_count) + 8'h01)
        else $error("sync lost not reported");

    a_one_frame: assert property (
        @(posedge pclk) disable iff (!presetn)
        frame_corrupt && frame_start && !unsync |=> !frame_corrupt)
        else $error("corruption outlasted one frame");

    a_apb_two_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        access |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule

// >>> capture_pkg.sv
package capture_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] CAPT_ATTR_OFF  = 8'h00;
    localparam logic [7:0] VID_ATTR0_OFF  = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;
    localparam logic [7:0] IRQ_CLEAR_OFF  = 8'h14;
    localparam logic [7:0] IRQ_ENABLE_OFF = 8'h18;
    localparam logic [7:0] STATUS_OFF     = 8'h1C;
    localparam logic [7:0] PANEL_CTRL_OFF = 8'h20;

    // Field positions.
    localparam int CAPT_EN_BIT     = 0;
    localparam int CAPT_SEL_BIT    = 19;
    localparam int VID_EN_BIT      = 0;
    localparam int VID_ROUTE_BIT   = 1;
    localparam int PANEL_ON_BIT    = 0;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_SYNC_BIT    = 1;
    localparam int STAT_BUSY_BIT   = 3;
    localparam int STAT_CORR_BIT   = 4;
    localparam int STAT_COUNT_LSB  = 8;

    // Reset values and sizes.
    localparam logic [31:0] REG_RESET  = 32'h0000_0000;
    localparam int          IRQ_W      = 2;
    localparam int          NUM_PIPES  = 3;

    // Timing counts in pclk cycles.
    localparam int PASS_CYCLES  = 64;
    localparam int FRAME_CYCLES = 1024;

    typedef enum logic [1:0] {
        CAP_IDLE = 2'b01,
        CAP_RUN  = 2'b10
    } cap_state_t;

endpackage

// >>> panel_frame_timer.sv
`timescale 1ns/1ns
module panel_frame_timer #(
    parameter int unsigned FRAME_CYCLES = capture_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Panel control and timing
    input  wire logic panel_on,
    output logic      frame_start
);
    import capture_pkg::*;

    localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYCLES - 1);

    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_frame_start;

    // The counter restarts whenever the panel is off, so the first frame
    // start comes one whole frame after the panel is switched on.
    always_comb begin
        next_count       = count;
        next_frame_start = 1'b0;
        if (!panel_on) begin
            next_count = 32'h0000_0000;
        end else if (count == FRAME_LAST) begin
            next_count       = 32'h0000_0000;
            next_frame_start = 1'b1;
        end else begin
            next_count = count + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count       <= 32'h0000_0000;
            frame_start <= 1'b0;
        end else begin
            count       <= next_count;
            frame_start <= next_frame_start;
        end
    end

endmodule

// >>> panel_sink.sv
`timescale 1ns/1ns
// Panel-side observer: counts the frames that reach the panel corrupted.
// It only watches the block, so it cannot itself cause a sync loss.
module panel_sink (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Panel state from the block
    input  wire logic       frame_corrupt,
    output logic [7:0]      corrupt_frames
);
    logic was_corrupt;
    logic [7:0] next_corrupt_frames;

    always_comb begin
        next_corrupt_frames = corrupt_frames;
        if (frame_corrupt && !was_corrupt) begin
            next_corrupt_frames = corrupt_frames + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            was_corrupt    <= 1'b0;
            corrupt_frames <= 8'h00;
        end else begin
            was_corrupt    <= frame_corrupt;
            corrupt_frames <= next_corrupt_frames;
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import capture_pkg::*;
    // Short counts keep the run brief.
    localparam int PASS_N  = 8;
    localparam int FRAME_N = 32;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [2:0]  panel_live;
    logic        frame_corrupt;
    logic        capture_busy;
    logic [7:0]  corrupt_frames;
    int          failures;
    int          num_checks;
    logic [31:0] rd;
    logic        err;

    capture_pipe_ctrl #(
        .PASS_CYCLES (PASS_N),
        .FRAME_CYCLES(FRAME_N)
    ) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .panel_live(panel_live), .frame_corrupt(frame_corrupt),
        .capture_busy(capture_busy)
    );

    panel_sink sink_u (
        .pclk(pclk), .presetn(presetn), .frame_corrupt(frame_corrupt),
        .corrupt_frames(corrupt_frames)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic results();
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
        apb(1'b1, addr, wdata);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr,
                          input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    // Sel 0 watches capture_busy, sel 1 watches layer 0 going live.
    task automatic wait_sig(input int sel, input logic val);
        int n;
        logic s;
        n = 0;
        s = ~val;
        while (s !== val && n < 200) begin
            @(posedge pclk);
            n++;
            s = (sel == 0) ? capture_busy : panel_live[0];
        end
        if (s !== val) begin
            failures++;
            results();
        end
    endtask

    task automatic run_pass();
        wr(VID_ATTR0_OFF, 32'h0000_0003);
        wr(CAPT_ATTR_OFF, 32'h0008_0001);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        failures = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("status", STATUS_OFF, REG_RESET);
        chk("mapped_err", 32'h0, {31'h0, err});
        rd_chk("capt_attr", CAPT_ATTR_OFF, REG_RESET);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        wr(IRQ_ENABLE_OFF, 32'h0000_0003);
        // First pass: hardware drops only the capture enable.
        run_pass();
        rd_chk("capt_attr", CAPT_ATTR_OFF, 32'h0008_0000);
        rd_chk("vid_attr", VID_ATTR0_OFF, 32'h0000_0003);
        rd_chk("irq_status", IRQ_STATUS_OFF, 32'h0000_0001);
        chk("irq", 32'h1, {31'h0, irq});
        wr(IRQ_CLEAR_OFF, 32'h0000_0001);
        rd_chk("irq_status", IRQ_STATUS_OFF, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        // Stale layer pushed straight onto the live panel.
        wr(PANEL_CTRL_OFF, 32'h0000_0001);
        wr(VID_ATTR0_OFF, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("live", 32'h1, {31'h0, panel_live[0]});
        chk("irq", 32'h1, {31'h0, irq});
        repeat (3 * FRAME_N) @(posedge pclk);
        chk("corrupt_frames", 32'h1, {24'h0, corrupt_frames});
        rd_chk("status", STATUS_OFF, 32'h0000_0101);
        rd_chk("irq_status", IRQ_STATUS_OFF, 32'h0000_0002);
        wr(IRQ_CLEAR_OFF, 32'h0000_0002);
        // Second pass with the done event masked.
        wr(IRQ_ENABLE_OFF, 32'h0000_0002);
        wr(VID_ATTR0_OFF, 32'h0000_0000);
        run_pass();
        rd_chk("irq_status", IRQ_STATUS_OFF, 32'h0000_0001);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(IRQ_CLEAR_OFF, 32'h0000_0001);
        // Clean exit sequence; the layer must join at a frame start.
        wr(VID_ATTR0_OFF, 32'h0000_0002);
        wr(CAPT_ATTR_OFF, 32'h0008_0001);
        wr(CAPT_ATTR_OFF, 32'h0008_0000);
        chk("busy", 32'h0, {31'h0, capture_busy});
        wr(VID_ATTR0_OFF, 32'h0000_0000);
        wr(VID_ATTR0_OFF, 32'h0000_0001);
        wait_sig(1, 1'b1);
        rd_chk("irq_status", IRQ_STATUS_OFF, 32'h0000_0000);
        chk("corrupt_frames", 32'h1, {24'h0, corrupt_frames});
        rd_chk("status", STATUS_OFF, 32'h0000_0101);
        results();
    end
endmodule
